// file: msms_pkg.sv
// constants, field layouts and state codes of the motor stop-mode sequencer
// assumes one 250 MHz clock; settings are in 0.01 Hz, 0.01 s and percent
package msms_pkg;

    // clock and sequencer tick
    localparam int unsigned CLK_PERIOD_NS = 4;          // 250 MHz
    localparam int unsigned TICK_NS       = 10_000_000; // 10 ms step
    localparam int unsigned TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL      = 8'h00;
    localparam logic [7:0] OFS_INJ_FREQ  = 8'h04;
    localparam logic [7:0] OFS_BLOCK     = 8'h08;
    localparam logic [7:0] OFS_INJ_TIME  = 8'h0C;
    localparam logic [7:0] OFS_INJ_LEVEL = 8'h10;
    localparam logic [7:0] OFS_DWELL     = 8'h14;
    localparam logic [7:0] OFS_REF       = 8'h18;
    localparam logic [7:0] OFS_STEP      = 8'h1C;
    localparam logic [7:0] OFS_STATUS    = 8'h20;

    // control, dwell and status register fields
    localparam int unsigned CTRL_RUN_BIT   = 0;
    localparam int unsigned CTRL_MODE_LSB  = 4;
    localparam int unsigned CTRL_STALL_LSB = 8;
    localparam int unsigned STALL_PB_BIT   = 3;  // stall prevention on decel
    localparam int unsigned DWELL_TIME_LSB = 16;
    localparam int unsigned STAT_STATE_LSB = 16;
    localparam int unsigned STAT_STOP_BIT  = 20;

    // stop-mode codes
    localparam logic [2:0] MODE_DEC   = 3'h0;
    localparam logic [2:0] MODE_COAST = 3'h2;
    localparam logic [2:0] MODE_POWER = 3'h4;
    localparam logic [2:0] MODE_MAX   = 3'h4;

    // setting limits and reset values
    localparam logic [15:0] FREQ_MAX      = 16'h1770; // 60.00 Hz
    localparam logic [15:0] TIME_MAX      = 16'h1770; // 60.00 s
    localparam logic [7:0]  LEVEL_MAX     = 8'hC8;    // 200 %
    localparam logic [15:0] INJ_FREQ_RST  = 16'h01F4; // 5.00 Hz
    localparam logic [15:0] BLOCK_RST     = 16'h000A; // 0.10 s
    localparam logic [15:0] INJ_TIME_RST  = 16'h0064; // 1.00 s
    localparam logic [7:0]  INJ_LEVEL_RST = 8'h32;    // 50 %
    localparam logic [15:0] REF_RST       = 16'h1770;
    localparam logic [15:0] STEP_RST      = 16'h0005;

    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // sequencer states
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_RUN    = 3'b001,
        ST_DECEL  = 3'b010,
        ST_DWELL  = 3'b011,
        ST_BLOCK  = 3'b100,
        ST_INJECT = 3'b101
    } msms_state_t;

endpackage : msms_pkg

// file: msms_tick_div.sv
// divider that turns the system clock into a one-cycle step enable
// assumes a synchronous active-high reset in the same clock domain
`timescale 1ns/1ns
`default_nettype none
module msms_tick_div #(
    parameter int unsigned CYCLES = 2
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic sys_rst,
    // step enable
    output logic      tick
);
    logic [31:0] cnt_q; // cycles since last tick
    logic [31:0] cnt_d;
    logic        tick_d;

    // next count and pulse
    always_comb begin
        tick_d = (cnt_q == CYCLES - 1);
        cnt_d  = tick_d ? 32'h0000_0000 : cnt_q + 32'h0000_0001;
    end

    // registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cnt_q <= 32'h0000_0000;
            tick  <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick  <= tick_d;
        end
    end
endmodule : msms_tick_div
`default_nettype wire

// file: msms_seq.sv
// stop-mode sequencer: ramps, dwell, output block, dc injection, braking
// assumes an axi4-lite master and a power stage sampling the outputs
//
// The register addresses and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
// Contract
// R1: mode codes 0-4, mode 0 ramps to 0
// R2: dc mode decelerates, injects at start frequency
// R3: output blocked for pre-brake interval first
// R4: dc applied for configured braking duration
// R5: injection level is percent of rated current
// R6: dwell below start frequency is skipped
// R7: coast mode switches output off at once
// R8: power braking re-accelerates on bus overvoltage
// R9: braking only decelerating, power braking wins
// R10: other codes select dc; then stop
// R11: zero interval or duration passes immediately
module msms_seq
    import msms_pkg::*;
#(
    parameter int unsigned TICK_CNT = TICK_CYCLES
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // axi4-lite write
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // power stage feedback
    input  wire logic        dc_bus_over,
    input  wire logic        stall_limit,
    // power stage commands
    output logic [15:0]      freq_out,
    output logic             out_enable,
    output logic             dc_inject,
    output logic [7:0]       injection_current_percent,
    output logic             drive_stopped
);
    // bus state
    logic        aw_hold_q, aw_hold_d;     // write address captured
    logic        w_hold_q,  w_hold_d;      // write data captured
    logic [7:0]  awaddr_q,  awaddr_d;
    logic [31:0] wdata_q,   wdata_d;
    logic [3:0]  wstrb_q,   wstrb_d;
    logic        bvalid_q,  bvalid_d;
    logic [1:0]  bresp_q,   bresp_d;
    logic        rvalid_q,  rvalid_d;
    logic [31:0] rdata_q,   rdata_d;
    logic [1:0]  rresp_q,   rresp_d;
    logic        wr_go;                    // commit a write this cycle
    // settings
    logic [31:0] ctrl_q, ctrl_d;           // run, mode, stall select
    logic [15:0] inj_freq_q, inj_freq_d;   // injection start frequency
    logic [15:0] block_q, block_d;         // pre-injection block time
    logic [15:0] inj_time_q, inj_time_d;   // injection time
    logic [7:0]  level_q, level_d;         // injection percent
    logic [31:0] dwell_q, dwell_d;         // dwell time and frequency
    logic [15:0] ref_q, ref_d;             // run frequency reference
    logic [15:0] step_q, step_d;           // frequency change per tick
    // sequencer
    msms_state_t state_q, state_d;
    logic [15:0] freq_q, freq_d;
    logic [15:0] cnt_q, cnt_d;             // ticks in a timed state
    logic        dwell_done_q, dwell_done_d;
    logic        tick;
    logic        run, dc_mode, pb_act, stall_act, dwell_go, time_up;
    logic [2:0]  mode;
    logic [15:0] dwell_freq, dwell_time, cur_time;

    assign s_axi_awready = !aw_hold_q && !bvalid_q;
    assign s_axi_wready  = !w_hold_q && !bvalid_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    // byte-lane merge of a write into an old value
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0]  strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = d[8*i +: 8];
            end
        end
        return r;
    endfunction : merge

    // frequency step with clamp at a limit
    function automatic logic [15:0] ramp(input logic [15:0] f,
                                         input logic [15:0] s,
                                         input logic [15:0] lim,
                                         input logic        up);
        logic [16:0] t;
        t = up ? {1'b0, f} + {1'b0, s} : {1'b0, f} - {1'b0, s};
        if (up) begin
            ramp = (t > {1'b0, lim}) ? lim : t[15:0];
        end else begin
            ramp = (t[16] || t[15:0] < lim) ? lim : t[15:0];
        end
    endfunction : ramp

    // step enable
    msms_tick_div #(.CYCLES(TICK_CNT)) u_tick (
        .clk     (clk),
        .sys_rst (sys_rst),
        .tick    (tick)
    );

    // bus handshakes and register writes
    always_comb begin
        logic [31:0] m;
        m          = 32'h0000_0000;
        aw_hold_d  = aw_hold_q;
        w_hold_d   = w_hold_q;
        awaddr_d   = awaddr_q;
        wdata_d    = wdata_q;
        wstrb_d    = wstrb_q;
        bvalid_d   = bvalid_q && !s_axi_bready;
        bresp_d    = bresp_q;
        rvalid_d   = rvalid_q && !s_axi_rready;
        rdata_d    = rdata_q;
        rresp_d    = rresp_q;
        ctrl_d     = ctrl_q;
        inj_freq_d = inj_freq_q;
        block_d    = block_q;
        inj_time_d = inj_time_q;
        level_d    = level_q;
        dwell_d    = dwell_q;
        ref_d      = ref_q;
        step_d     = step_q;
        wr_go      = aw_hold_q && w_hold_q && !bvalid_q;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_d = 1'b1;
            awaddr_d  = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_hold_d = 1'b1;
            wdata_d  = s_axi_wdata;
            wstrb_d  = s_axi_wstrb;
        end
        // commit the captured write; out-of-range settings keep old value
        if (wr_go) begin
            aw_hold_d = 1'b0;
            w_hold_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = RESP_OKAY;
            case (awaddr_q)
                OFS_CTRL: begin
                    m = merge(ctrl_q, wdata_q, wstrb_q);
                    if (m[CTRL_MODE_LSB +: 3] <= MODE_MAX) begin // R1
                        ctrl_d = m & 32'h0000_FF71;
                    end
                end
                OFS_INJ_FREQ: begin
                    m = merge({16'h0000, inj_freq_q}, wdata_q, wstrb_q);
                    if (m[15:0] <= FREQ_MAX) inj_freq_d = m[15:0]; // R2
                end
                OFS_BLOCK: begin
                    m = merge({16'h0000, block_q}, wdata_q, wstrb_q);
                    if (m[15:0] <= TIME_MAX) block_d = m[15:0]; // R3
                end
                OFS_INJ_TIME: begin
                    m = merge({16'h0000, inj_time_q}, wdata_q, wstrb_q);
                    if (m[15:0] <= TIME_MAX) inj_time_d = m[15:0]; // R4
                end
                OFS_INJ_LEVEL: begin
                    m = merge({24'h000000, level_q}, wdata_q, wstrb_q);
                    if (m[7:0] <= LEVEL_MAX) level_d = m[7:0]; // R5
                end
                OFS_DWELL: dwell_d = merge(dwell_q, wdata_q, wstrb_q);
                OFS_REF: begin
                    m = merge({16'h0000, ref_q}, wdata_q, wstrb_q);
                    ref_d = m[15:0];
                end
                OFS_STEP: begin
                    m = merge({16'h0000, step_q}, wdata_q, wstrb_q);
                    step_d = m[15:0];
                end
                OFS_STATUS: ;                   // read only, ignored
                default: bresp_d = RESP_SLVERR; // unmapped
            endcase
        end
        // read answer one cycle after the address is taken
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_d = 1'b1;
            rresp_d  = RESP_OKAY;
            case (s_axi_araddr)
                OFS_CTRL:      rdata_d = ctrl_q;
                OFS_INJ_FREQ:  rdata_d = {16'h0000, inj_freq_q};
                OFS_BLOCK:     rdata_d = {16'h0000, block_q};
                OFS_INJ_TIME:  rdata_d = {16'h0000, inj_time_q};
                OFS_INJ_LEVEL: rdata_d = {24'h000000, level_q};
                OFS_DWELL:     rdata_d = dwell_q;
                OFS_REF:       rdata_d = {16'h0000, ref_q};
                OFS_STEP:      rdata_d = {16'h0000, step_q};
                OFS_STATUS: begin
                    // frequency low, state and stopped flag above it
                    rdata_d = {16'h0000, freq_q};
                    rdata_d[STAT_STATE_LSB +: 3] = state_q;
                    rdata_d[STAT_STOP_BIT]       = state_q == ST_IDLE;
                end
                default: begin
                    rdata_d = 32'h0000_0000;
                    rresp_d = RESP_SLVERR;
                end
            endcase
        end
    end

    // bus and setting registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            aw_hold_q  <= 1'b0;
            w_hold_q   <= 1'b0;
            awaddr_q   <= 8'h00;
            wdata_q    <= 32'h0000_0000;
            wstrb_q    <= 4'h0;
            bvalid_q   <= 1'b0;
            bresp_q    <= RESP_OKAY;
            rvalid_q   <= 1'b0;
            rdata_q    <= 32'h0000_0000;
            rresp_q    <= RESP_OKAY;
            ctrl_q     <= 32'h0000_0000; // stop mode 0 by default
            inj_freq_q <= INJ_FREQ_RST;
            block_q    <= BLOCK_RST;
            inj_time_q <= INJ_TIME_RST;
            level_q    <= INJ_LEVEL_RST;
            dwell_q    <= 32'h0000_0000;
            ref_q      <= REF_RST;
            step_q     <= STEP_RST;
        end else begin
            aw_hold_q  <= aw_hold_d;
            w_hold_q   <= w_hold_d;
            awaddr_q   <= awaddr_d;
            wdata_q    <= wdata_d;
            wstrb_q    <= wstrb_d;
            bvalid_q   <= bvalid_d;
            bresp_q    <= bresp_d;
            rvalid_q   <= rvalid_d;
            rdata_q    <= rdata_d;
            rresp_q    <= rresp_d;
            ctrl_q     <= ctrl_d;
            inj_freq_q <= inj_freq_d;
            block_q    <= block_d;
            inj_time_q <= inj_time_d;
            level_q    <= level_d;
            dwell_q    <= dwell_d;
            ref_q      <= ref_d;
            step_q     <= step_d;
        end
    end

    // sequencer decisions and next values
    always_comb begin
        run        = ctrl_q[CTRL_RUN_BIT];
        mode       = ctrl_q[CTRL_MODE_LSB +: 3];
        dwell_freq = dwell_q[15:0];
        dwell_time = dwell_q[DWELL_TIME_LSB +: 16];
        dc_mode    = mode != MODE_DEC && mode != MODE_COAST
                     && mode != MODE_POWER;                      // R10
        pb_act     = mode == MODE_POWER && dc_bus_over;          // R8
        stall_act  = ctrl_q[CTRL_STALL_LSB + STALL_PB_BIT]
                     && stall_limit && !pb_act;                  // R9
        dwell_go   = !dwell_done_q && dwell_time != 16'h0000
                     && freq_q <= dwell_freq
                     && !(dc_mode && dwell_freq < inj_freq_q);  // R6
        cur_time   = state_q == ST_DWELL ? dwell_time :
                     state_q == ST_BLOCK ? block_q : inj_time_q;
        time_up    = tick && cnt_q + 16'h0001 >= cur_time;
        state_d      = state_q;
        freq_d       = freq_q;
        cnt_d        = tick ? cnt_q + 16'h0001 : cnt_q;
        dwell_done_d = dwell_done_q;
        case (state_q)
            ST_IDLE: begin
                freq_d       = 16'h0000;
                dwell_done_d = 1'b0;
                if (run) state_d = ST_RUN;
            end
            ST_RUN: begin
                if (!run && mode == MODE_COAST) begin
                    state_d = ST_IDLE;                           // R7
                    freq_d  = 16'h0000;
                end else if (!run) begin
                    state_d = ST_DECEL;
                end else if (tick) begin
                    freq_d = freq_q < ref_q ?
                             ramp(freq_q, step_q, ref_q, 1'b1) :
                             ramp(freq_q, step_q, ref_q, 1'b0);
                end
            end
            ST_DECEL: begin
                cnt_d = 16'h0000;
                if (run) begin
                    state_d = ST_RUN;
                end else if (dwell_go) begin
                    state_d = ST_DWELL;
                end else if (dc_mode && freq_q <= inj_freq_q) begin
                    freq_d = 16'h0000;                           // R2
                    if (block_q != 16'h0000) state_d = ST_BLOCK; // R3
                    else if (inj_time_q != 16'h0000)
                        state_d = ST_INJECT;                     // R11
                    else state_d = ST_IDLE;                      // R11
                end else if (!dc_mode && freq_q == 16'h0000) begin
                    state_d = ST_IDLE;                           // R1
                end else if (tick && pb_act) begin
                    freq_d = ramp(freq_q, step_q, ref_q, 1'b1);  // R8
                end else if (tick && !stall_act) begin
                    freq_d = ramp(freq_q, step_q, 16'h0000, 1'b0);
                end
            end
            ST_DWELL: begin
                if (run) begin
                    state_d = ST_RUN;
                end else if (time_up) begin
                    state_d      = ST_DECEL;
                    dwell_done_d = 1'b1;
                end
            end
            ST_BLOCK: begin
                if (time_up) begin
                    cnt_d   = 16'h0000;
                    state_d = inj_time_q != 16'h0000 ?
                              ST_INJECT : ST_IDLE;               // R11
                end
            end
            ST_INJECT: begin
                if (time_up) state_d = ST_IDLE;                  // R4 R10
            end
            default: state_d = ST_IDLE;
        endcase
    end

    // sequencer and output registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q                   <= ST_IDLE;
            freq_q                    <= 16'h0000;
            cnt_q                     <= 16'h0000;
            dwell_done_q              <= 1'b0;
            freq_out                  <= 16'h0000;
            out_enable                <= 1'b0;
            dc_inject                 <= 1'b0;
            injection_current_percent <= 8'h00;
            drive_stopped             <= 1'b1;
        end else begin
            state_q      <= state_d;
            freq_q       <= freq_d;
            cnt_q        <= cnt_d;
            dwell_done_q <= dwell_done_d;
            freq_out     <= freq_d;
            out_enable   <= state_d == ST_RUN || state_d == ST_DECEL
                            || state_d == ST_DWELL;              // R3 R7
            dc_inject    <= state_d == ST_INJECT;                // R4
            injection_current_percent <=
                state_d == ST_INJECT ? level_q : 8'h00;          // R5
            drive_stopped <= state_d == ST_IDLE;                 // R10
        end
    end

    // checks
    sequence s_dc_entry;
        state_q == ST_DECEL && !run && dc_mode && !dwell_go
        && freq_q <= inj_freq_q;
    endsequence

    a_mode_in_range: assert property (@(posedge clk) disable iff (sys_rst)
        mode <= MODE_MAX) else $error("stop mode code out of range"); // R1
    a_dec_to_idle: assert property (@(posedge clk) disable iff (sys_rst)
        (state_q == ST_DECEL && mode == MODE_DEC && !run && !dwell_go
         && freq_q == 16'h0000) |=> drive_stopped && !out_enable)
        else $error("decel stop did not end"); // R1
    a_block_first: assert property (@(posedge clk) disable iff (sys_rst)
        s_dc_entry and (block_q != 16'h0000)
        |=> state_q == ST_BLOCK && !out_enable && !dc_inject)
        else $error("output not blocked before injection"); // R2 R3
    a_zero_block: assert property (@(posedge clk) disable iff (sys_rst)
        s_dc_entry and (block_q == 16'h0000) and (inj_time_q != 16'h0000)
        |=> dc_inject) else $error("zero block time added delay"); // R11
    a_inject_end: assert property (@(posedge clk) disable iff (sys_rst)
        (state_q == ST_INJECT && time_up) |=> drive_stopped && !dc_inject)
        else $error("injection did not end in stop"); // R4 R10
    a_level_out: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(dc_inject) |-> injection_current_percent == $past(level_q))
        else $error("injection level wrong"); // R5
    a_dwell_skip: assert property (@(posedge clk) disable iff (sys_rst)
        (state_q == ST_DECEL && dc_mode && dwell_freq < inj_freq_q)
        |=> state_q != ST_DWELL) else $error("dwell not skipped"); // R6
    a_coast_off: assert property (@(posedge clk) disable iff (sys_rst)
        (state_q == ST_RUN && !run && mode == MODE_COAST)
        |=> !out_enable && freq_out == 16'h0000)
        else $error("coast did not switch output off"); // R7
    a_pb_reaccel: assert property (@(posedge clk) disable iff (sys_rst)
        (state_q == ST_DECEL && state_d == ST_DECEL && tick && pb_act
         && freq_q < ref_q && step_q != 16'h0000)
        |=> freq_q > $past(freq_q)) else $error("no power braking"); // R8
    a_stall_hold: assert property (@(posedge clk) disable iff (sys_rst)
        (state_q == ST_DECEL && state_d == ST_DECEL && tick && !pb_act
         && stall_act) |=> $stable(freq_q))
        else $error("stall prevention did not hold"); // R9
    a_write_resp: assert property (@(posedge clk) disable iff (sys_rst)
        (aw_hold_q && w_hold_q && !bvalid_q) |=> bvalid_q)
        else $error("write response missing");
endmodule : msms_seq
`default_nettype wire

// file: msms_power_stage.sv
// power stage model: regenerates onto the dc bus when asked to
// assumes the sequencer's output enable; feedback is combinational
`timescale 1ns/1ns
`default_nettype none
module msms_power_stage (
    // commands seen
    input  wire logic out_enable,
    input  wire logic regen_req,
    // feedback to the sequencer
    output logic      dc_bus_over,
    output logic      stall_limit
);
    // the bus only rises while the stage really drives the motor
    assign dc_bus_over = regen_req && (out_enable === 1'b1);
    // a regenerating load also pulls the current to its limit
    assign stall_limit = regen_req && (out_enable === 1'b1);
endmodule : msms_power_stage
`default_nettype wire

// file: tb_msms_seq.sv
// testbench of the stop-mode sequencer beside a power stage model
// assumes msms_pkg, msms_seq and msms_power_stage compiled first
`timescale 1ns/1ns
`default_nettype none
module tb_msms_seq
    import msms_pkg::*;
;
    logic        clk, sys_rst, awv, wv, bry, arv, rry, regen, dc, sh;
    logic [15:0] fh;
    logic [7:0]  awa, ara, lvs;
    logic [31:0] wd, rdat, lv;
    logic [3:0]  ws;
    logic [2:0]  m;
    logic [1:0]  rrsp;
    wire logic   awr, wrdy, bv, arr, rv, ov, stl, oe, inj, stp;
    wire logic [1:0]  brw, rrw;
    wire logic [31:0] rdw;
    wire logic [15:0] fq;
    wire logic [7:0]  lvo;
    int failures = 0;
    int num_checks = 0;
    int ic, bc, oc;
    localparam int TCK = 10; // cycles per sequencer step in this bench
    logic [7:0]  ofs [9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14,
                             8'h18, 8'h1C, 8'h20};
    logic [31:0] rsv [9] = '{32'h0, 32'h1F4, 32'hA, 32'h64, 32'h32, 32'h0,
                             32'h1770, 32'h5, 32'h0010_0000};
    // short step so each stop runs in tens of cycles
    msms_seq #(.TICK_CNT(TCK)) i_msms_seq (.clk(clk), .sys_rst(sys_rst),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
        .s_axi_wready(wrdy), .s_axi_bresp(brw), .s_axi_bvalid(bv),
        .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdw), .s_axi_rresp(rrw),
        .s_axi_rvalid(rv), .s_axi_rready(rry), .dc_bus_over(ov),
        .stall_limit(stl), .freq_out(fq), .out_enable(oe),
        .dc_inject(inj), .injection_current_percent(lvo),
        .drive_stopped(stp));
    msms_power_stage i_msms_power_stage (.out_enable(oe),
        .regen_req(regen), .dc_bus_over(ov), .stall_limit(stl));
    // axi4-lite write, each channel released at its own handshake
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        awa <= a;
        wd <= d;
        ws <= s;
        {awv, wv, bry} <= 3'h7;
        do begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wrdy) wv <= 1'b0;
        end while (bv !== 1'b1);
        bry <= 1'b0;
        @(posedge clk);
    endtask : wr
    // axi4-lite read, data taken at the rvalid edge
    task automatic rd(input logic [7:0] a);
        ara <= a;
        {arv, rry} <= 2'h3;
        do begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
        end while (rv !== 1'b1);
        rdat = rdw;
        rrsp = rrw;
        rry <= 1'b0;
        @(posedge clk);
    endtask : rd
    // value compare
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] s);
        num_checks++;
        if (s !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic conclude();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : conclude
    // longest span in cycles of a timed state of n steps
    function automatic int span(input int n);
        return n * TCK;
    endfunction : span
    // 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // watchdog well past the planned run
    initial begin
        #200000;
        failures++;
        conclude();
    end
    // main sequence
    initial begin
        {sys_rst, awv, wv, bry, arv, rry, regen} = 7'h40;
        {awa, ara, wd, ws} = {16'h0, 32'h0, 4'hF};
        void'($urandom(78568));
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 9; i++) begin
            rd(ofs[i]);
            chk("reset value", rsv[i], rdat);
        end
        rd(8'h24);
        chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, rrsp});
        wr(OFS_CTRL, 32'h51, 4'hF);
        wr(OFS_INJ_FREQ, 32'h1771, 4'hF);
        rd(OFS_CTRL);
        chk("mode 5 refused", 32'h0, rdat);
        rd(OFS_INJ_FREQ);
        chk("freq limit", 32'h1F4, rdat);
        lv = $urandom_range(200);
        wr(OFS_INJ_LEVEL, 32'hFFFF_FF00 | lv, 4'h1);
        wr(OFS_REF, 32'h64, 4'hF);
        wr(OFS_STEP, 32'h14, 4'hF);
        wr(OFS_BLOCK, 32'h2, 4'hF);
        wr(OFS_INJ_TIME, 32'h3, 4'hF);
        for (int i = 0; i < 6; i++) begin
            m = (i == 5) ? 3'h1 : 3'(i);
            dc = (m == 3'h1 || m == 3'h3);
            if (i == 5) begin
                wr(OFS_BLOCK, 32'h0, 4'hF);
                wr(OFS_DWELL, 32'h0003_00C8, 4'hF);
            end
            wr(OFS_CTRL, {25'h0, m, 4'h1}, 4'hF);
            repeat (100) @(posedge clk);
            chk("run freq", 32'h64, {16'h0, fq});
            // stall select on in modes 0 and 4; regen comes while the ramp is still falling
            sh = (m == MODE_POWER || m == MODE_DEC);
            wr(OFS_CTRL, {20'h0, sh, 4'h0, m, 4'h0}, 4'hF);
            ic = 0;
            bc = 0;
            oc = 0;
            if (sh) begin
                repeat (25) @(posedge clk);
                regen <= 1'b1;
                repeat (2) @(posedge clk);
                fh = fq;
                repeat (60) @(posedge clk);
                if (m == MODE_POWER)
                    chk("power braking", 32'h64, {16'h0, fq});
                else
                    chk("stall hold", {16'h0, fh}, {16'h0, fq});
                regen <= 1'b0;
            end
            if (m == MODE_COAST) begin
                repeat (2) @(posedge clk);
                chk("coast off", 1, !oe && fq === 16'h0 && stp);
            end
            for (int k = 0; k < 400 && stp !== 1'b1; k++) begin
                @(posedge clk);
                if (inj === 1'b1) ic++;
                if (inj === 1'b1) lvs = lvo;
                if (oe === 1'b1) oc++;
                if (oe === 1'b0 && inj === 1'b0 && stp === 1'b0) bc++;
            end
            chk("inject time", 1, dc ? (ic > span(2) && ic <= span(3)) : ic == 0);
            chk("block time", 1, (dc && i < 5) ? (bc > span(1) && bc <= span(2)) : bc == 0);
            if (dc) chk("dwell skip", 0, oc);
            if (dc) chk("inject level", lv, {24'h0, lvs});
            chk("stopped", 1, stp === 1'b1 && fq === 16'h0);
        end
        conclude();
    end
endmodule : tb_msms_seq
`default_nettype wire
